// ===== design/sample_seq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sample_seq_ctrl #(
  parameter int DATA_W      = 10,
  parameter int CONV_CYCLES = seq_ctrl_pkg::CONV_CYCLES
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic [3:0]        seq_enable_i,
  input  wire logic [15:0]       seq_trig_sel_i,
  input  wire logic [7:0]        seq_prio_i,
  input  wire logic [11:0]       seq_last_step_i,
  input  wire logic [3:0]        phase_sel_i,
  input  wire logic              ref_wr_i,
  input  wire logic              ref_wr_data_i,
  output logic                   external_reference_sel_o,
  input  wire logic              sw_start_i,
  input  wire logic [1:0]        sw_start_seq_i,
  input  wire logic              sw_hold_i,
  input  wire logic              sw_release_i,
  input  wire logic              peer_release_i,
  output logic                   release_o,
  input  wire logic              analog_cmp_a_source_i,
  input  wire logic              analog_cmp_b_source_i,
  input  wire logic              analog_cmp_c_source_i,
  input  wire logic              ext_trig_pin_i,
  input  wire logic              timer_trig_i,
  input  wire logic              pulse_gen_a_source_i,
  input  wire logic              pulse_gen_b_source_i,
  input  wire logic              pulse_gen_c_source_i,
  input  wire logic              pulse_gen_d_source_i,
  output logic                   conv_start_o,
  output logic [1:0]             conv_seq_o,
  output logic [2:0]             conv_step_o,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  input  wire logic              rd_req_i,
  input  wire logic [1:0]        rd_seq_i,
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic [15:0]            fifo_count_o,
  output logic [3:0]             overflow_o,
  output logic [3:0]             underflow_o,
  input  wire logic [3:0]        overflow_clr_i,
  input  wire logic [3:0]        underflow_clr_i,
  output logic                   busy_o
);
  localparam int NS = seq_ctrl_pkg::NUM_SEQ;
  localparam int CW = seq_ctrl_pkg::CNT_W;
  localparam int SW = seq_ctrl_pkg::STEP_W;
  localparam int DW = 16;

  initial begin
    if (CONV_CYCLES < seq_ctrl_pkg::PHASE_STEPS || CONV_CYCLES > 4096) begin
      $error("CONV_CYCLES out of range");
    end
    if (DATA_W < 1) begin
      $error("DATA_W must be positive");
    end
  end

  // Depth of each sequence FIFO
  function automatic logic [CW-1:0] seq_depth(input logic [1:0] s);
    case (s)
      2'h0:    seq_depth = seq_ctrl_pkg::DEPTH_SEQ0;
      2'h1:    seq_depth = seq_ctrl_pkg::DEPTH_SEQ1;
      2'h2:    seq_depth = seq_ctrl_pkg::DEPTH_SEQ2;
      default: seq_depth = seq_ctrl_pkg::DEPTH_SEQ3;
    endcase
  endfunction : seq_depth

  // Advance a ring pointer inside one sequence's depth
  function automatic logic [SW-1:0] ptr_inc(input logic [SW-1:0] p, input logic [1:0] s);
    logic [CW-1:0] nx;
    nx = {1'b0, p} + 4'h1;
    ptr_inc = (nx >= seq_depth(s)) ? 3'h0 : nx[SW-1:0];
  endfunction : ptr_inc

  // Phase k in clock cycles: k sixteenths of a conversion period
  function automatic logic [DW-1:0] phase_cycles(input logic [3:0] k);
    phase_cycles = DW'((32'(k) * 32'(CONV_CYCLES)) / 32'(seq_ctrl_pkg::PHASE_STEPS));
  endfunction : phase_cycles

  seq_mem_if #(.DATA_W(DATA_W), .ADDR_W(seq_ctrl_pkg::MEM_ADDR_W)) mem_bus ();

  seq_sample_mem #(.DEPTH(seq_ctrl_pkg::MEM_DEPTH)) u_mem (
    .clk_sys_i (clk_sys_i),
    .mem_p     (mem_bus.mem)
  );

  // External pin synchroniser and edge detect
  logic ext_meta_r, ext_sync_r, ext_prev_r;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_trig_pin_i;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // Source vector indexed by trigger code
  logic [15:0] src_vec;
  always_comb begin
    src_vec = 16'h0000;
    src_vec[seq_ctrl_pkg::TRIG_CMP_A]    = analog_cmp_a_source_i;
    src_vec[seq_ctrl_pkg::TRIG_CMP_B]    = analog_cmp_b_source_i;
    src_vec[seq_ctrl_pkg::TRIG_CMP_C]    = analog_cmp_c_source_i;
    src_vec[seq_ctrl_pkg::TRIG_EXTERNAL] = ext_sync_r & ~ext_prev_r;
    src_vec[seq_ctrl_pkg::TRIG_TIMER]    = timer_trig_i;
    src_vec[seq_ctrl_pkg::TRIG_PWM_A]    = pulse_gen_a_source_i;
    src_vec[seq_ctrl_pkg::TRIG_PWM_B]    = pulse_gen_b_source_i;
    src_vec[seq_ctrl_pkg::TRIG_PWM_C]    = pulse_gen_c_source_i;
    src_vec[seq_ctrl_pkg::TRIG_PWM_D]    = pulse_gen_d_source_i;
    src_vec[seq_ctrl_pkg::TRIG_ALWAYS]   = 1'b1;
  end

  // Per-sequence trigger hits, software starts and held starts
  logic [NS-1:0] hw_hit, sw_hit, hold_set, held_r, pend_r;
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      logic [3:0] sel;
      sel = seq_trig_sel_i[s*4 +: 4];
      hw_hit[s] = (sel != seq_ctrl_pkg::TRIG_PROCESSOR) && src_vec[sel];
      // Processor request counts only on processor-triggered sequences
      sw_hit[s] = sw_start_i && !sw_hold_i && (sw_start_seq_i == 2'(s))
                  && (sel == seq_ctrl_pkg::TRIG_PROCESSOR);
      hold_set[s] = sw_start_i && sw_hold_i && (sw_start_seq_i == 2'(s))
                    && (sel == seq_ctrl_pkg::TRIG_PROCESSOR);
    end
  end

  // Release pulse goes to the peer modules, not to this one
  assign release_o = sw_start_i && sw_release_i;

  // Held software starts wait for a peer release
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      held_r <= 4'h0;
    end else if (peer_release_i) begin
      held_r <= hold_set;
    end else begin
      held_r <= (held_r | hold_set) & seq_enable_i;
    end
  end

  seq_ctrl_pkg::seq_state_t state_r;
  logic [1:0]    cur_seq_r;
  logic [SW-1:0] step_r;
  logic [DW-1:0] delay_cnt_r;
  logic          wait_done_r;
  logic [NS-1:0] start_now;
  logic [NS-1:0] trig_now;

  // Trigger events, gated by enable
  assign trig_now = (hw_hit | sw_hit | (peer_release_i ? held_r : 4'h0))
                    & seq_enable_i;

  // Pending flags: set on trigger, cleared when the sequence starts
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= ((pend_r & ~start_now) | trig_now) & seq_enable_i;
    end
  end

  // Highest-priority pending sequence; unique priorities assumed
  logic       pick_vld;
  logic [1:0] pick_seq;
  logic [1:0] pick_prio;
  always_comb begin
    pick_vld  = 1'b0;
    pick_seq  = 2'h0;
    pick_prio = 2'h3;
    for (int s = 0; s < NS; s++) begin
      if (pend_r[s] && (!pick_vld || seq_prio_i[s*2 +: 2] < pick_prio)) begin
        pick_vld  = 1'b1;
        pick_seq  = 2'(s);
        pick_prio = seq_prio_i[s*2 +: 2];
      end
    end
  end

  logic [SW-1:0] last_step;
  logic [CW-1:0] last_lim;
  logic          seq_end;
  assign last_lim  = seq_depth(cur_seq_r) - 4'h1;
  assign last_step = ({1'b0, seq_last_step_i[cur_seq_r*3 +: 3]} > last_lim)
                     ? last_lim[SW-1:0] : seq_last_step_i[cur_seq_r*3 +: 3];
  assign seq_end   = conv_done_i && (step_r == last_step);
  assign start_now = (state_r == seq_ctrl_pkg::ST_IDLE && pick_vld)
                     ? (4'h1 << pick_seq) : 4'h0;

  // Sequencer: pick, phase delay, walk the steps
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r      <= seq_ctrl_pkg::ST_IDLE;
      cur_seq_r    <= 2'h0;
      step_r       <= 3'h0;
      delay_cnt_r  <= 16'h0000;
      conv_start_o <= 1'b0;
      wait_done_r  <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (state_r)
        seq_ctrl_pkg::ST_IDLE: begin
          if (pick_vld) begin
            cur_seq_r   <= pick_seq;
            step_r      <= 3'h0;
            // One module-wide phase for every sequence
            delay_cnt_r <= phase_cycles(phase_sel_i);
            state_r     <= seq_ctrl_pkg::ST_DELAY;
          end
        end
        seq_ctrl_pkg::ST_DELAY: begin
          if (delay_cnt_r == 16'h0000) begin
            conv_start_o <= 1'b1;
            wait_done_r  <= 1'b1;
            state_r      <= seq_ctrl_pkg::ST_CONV;
          end else begin
            delay_cnt_r <= delay_cnt_r - 16'h0001;
          end
        end
        seq_ctrl_pkg::ST_CONV: begin
          if (conv_done_i && wait_done_r) begin
            if (seq_end) begin
              // Always-triggered sequences re-arm through the pending flag
              wait_done_r <= 1'b0;
              state_r     <= seq_ctrl_pkg::ST_IDLE;
            end else begin
              step_r       <= step_r + 3'h1;
              conv_start_o <= 1'b1;
            end
          end
        end
        default: state_r <= seq_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  assign conv_seq_o  = cur_seq_r;
  assign conv_step_o = step_r;
  assign busy_o      = (state_r != seq_ctrl_pkg::ST_IDLE);

  // FIFO bookkeeping
  logic [SW-1:0] wr_ptr_r [NS];
  logic [SW-1:0] rd_ptr_r [NS];
  logic [CW-1:0] count_r  [NS];
  logic          do_wr, do_rd;
  assign do_wr = (state_r == seq_ctrl_pkg::ST_CONV) && conv_done_i
                 && (count_r[cur_seq_r] < seq_depth(cur_seq_r));
  assign do_rd = rd_req_i && (count_r[rd_seq_i] != 4'h0);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int s = 0; s < NS; s++) begin
        wr_ptr_r[s] <= 3'h0;
        rd_ptr_r[s] <= 3'h0;
        count_r[s]  <= 4'h0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        logic w, r;
        w = do_wr && (cur_seq_r == 2'(s));
        r = do_rd && (rd_seq_i == 2'(s));
        if (w) wr_ptr_r[s] <= ptr_inc(wr_ptr_r[s], 2'(s));
        if (r) rd_ptr_r[s] <= ptr_inc(rd_ptr_r[s], 2'(s));
        count_r[s] <= count_r[s] + {3'h0, w} - {3'h0, r};
      end
    end
  end

  assign mem_bus.wr_en   = do_wr;
  assign mem_bus.wr_addr = {cur_seq_r, wr_ptr_r[cur_seq_r]};
  assign mem_bus.wr_data = conv_data_i;
  assign mem_bus.rd_en   = do_rd;
  assign mem_bus.rd_addr = {rd_seq_i, rd_ptr_r[rd_seq_i]};
  assign rd_data_o       = mem_bus.rd_data;

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      fifo_count_o[s*4 +: 4] = count_r[s];
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  logic [NS-1:0] ovf_set, unf_set;
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      ovf_set[s] = start_now[s] && (count_r[s] != 4'h0);
      unf_set[s] = rd_req_i && (rd_seq_i == 2'(s)) && (count_r[s] == 4'h0);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      overflow_o  <= 4'h0;
      underflow_o <= 4'h0;
      rd_valid_o  <= 1'b0;
    end else begin
      overflow_o  <= (overflow_o & ~overflow_clr_i) | ovf_set;
      underflow_o <= (underflow_o & ~underflow_clr_i) | unf_set;
      rd_valid_o  <= do_rd;
    end
  end

  // Reference select, read back on its own output
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      external_reference_sel_o <= seq_ctrl_pkg::REF_RESET;
    end else if (ref_wr_i) begin
      external_reference_sel_o <= ref_wr_data_i;
    end
  end
endmodule : sample_seq_ctrl
`default_nettype wire

// ===== design/seq_sample_mem.sv
`timescale 1ns/1ps
`default_nettype none
module seq_sample_mem #(
  parameter int DEPTH = 32
) (
  input  wire logic clk_sys_i,
  seq_mem_if.mem    mem_p
);
  logic [$bits(mem_p.wr_data)-1:0] store_r [DEPTH];

  // Every address the port can form must land inside the array
  initial begin
    if (DEPTH < (1 << $bits(mem_p.wr_addr))) begin
      $error("DEPTH too small for address width");
    end
  end

  // No reset on the array; contents are only read after being written
  always_ff @(posedge clk_sys_i) begin
    if (mem_p.wr_en) begin
      store_r[mem_p.wr_addr] <= mem_p.wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys_i) begin
    if (mem_p.rd_en) begin
      mem_p.rd_data <= store_r[mem_p.rd_addr];
    end
  end
endmodule : seq_sample_mem
`default_nettype wire

// ===== inc/seq_ctrl_pkg.sv
// Behaviour
// - Programmable delay of sixteen equal phase steps between trigger detect and sequence start.
// - One phase setting per module, applied to all four sequences.
// - Two modules set half a period apart interleave samples on one input.
// - Software start only acts on sequences whose trigger is processor-initiated.
// - A held software start waits for a release issued by another module.
// - Reference select is readable and writable: internal or external pin reference.
// - Four sequences holding eight, four, four and one samples.
// - Per-sequence trigger select: software, three comparators, pin, timer, four PWMs, always.
// - Always-triggered sequence restarts after each completion, yielding to higher priority.
// - Per-sequence priority 0 to 3, zero highest.
// - Each output FIFO reports its fill level; reads return only held samples.
// - Disabled sequences ignore triggers; a run already under way when its enable drops still completes and captures.
// - Enabled sequences capture once their selected trigger is detected and they win priority, while their FIFO has room; triggers already pending merge.
// - Sticky overflow flag when a sequence start finds unread samples; cleared by software.
// - Sticky underflow flag when a read finds the FIFO empty; cleared by software.
package seq_ctrl_pkg;
  localparam int NUM_SEQ        = 4;
  localparam int SEQ_IDX_W      = 2;
  localparam int STEP_W         = 3;
  localparam int CNT_W          = 4;
  localparam int MEM_DEPTH      = 32;
  localparam int MEM_ADDR_W     = 5;
  // Sequence depths
  localparam logic [CNT_W-1:0] DEPTH_SEQ0 = 4'h8;
  localparam logic [CNT_W-1:0] DEPTH_SEQ1 = 4'h4;
  localparam logic [CNT_W-1:0] DEPTH_SEQ2 = 4'h4;
  localparam logic [CNT_W-1:0] DEPTH_SEQ3 = 4'h1;
  // Trigger select codes
  localparam int TRIG_W = 4;
  localparam logic [TRIG_W-1:0] TRIG_PROCESSOR = 4'h0;
  localparam logic [TRIG_W-1:0] TRIG_CMP_A     = 4'h1;
  localparam logic [TRIG_W-1:0] TRIG_CMP_B     = 4'h2;
  localparam logic [TRIG_W-1:0] TRIG_CMP_C     = 4'h3;
  localparam logic [TRIG_W-1:0] TRIG_EXTERNAL  = 4'h4;
  localparam logic [TRIG_W-1:0] TRIG_TIMER     = 4'h5;
  localparam logic [TRIG_W-1:0] TRIG_PWM_A     = 4'h6;
  localparam logic [TRIG_W-1:0] TRIG_PWM_B     = 4'h7;
  localparam logic [TRIG_W-1:0] TRIG_PWM_C     = 4'h8;
  localparam logic [TRIG_W-1:0] TRIG_PWM_D     = 4'h9;
  localparam logic [TRIG_W-1:0] TRIG_ALWAYS    = 4'hF;
  // Phase and timing
  localparam int PHASE_W        = 4;
  localparam int PHASE_STEPS    = 16;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CONV_PERIOD_NS = 400;
  localparam int CONV_CYCLES    = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reference select values
  localparam logic REF_INTERNAL = 1'b0;
  localparam logic REF_EXTERNAL = 1'b1;
  localparam logic REF_RESET    = REF_INTERNAL;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONV  = 3'b100
  } seq_state_t;
endpackage : seq_ctrl_pkg

// ===== inc/seq_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seq_mem_if #(
  parameter int DATA_W = 10,
  parameter int ADDR_W = 5
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface : seq_mem_if
`default_nettype wire

// ===== tb/seq_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_asserts #(
  parameter int CONV_CYCLES = 16
) (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  phase_sel_i,
  input wire logic        ref_wr_i,
  input wire logic        ref_wr_data_i,
  input wire logic        external_reference_sel_o,
  input wire logic        sw_start_i,
  input wire logic        sw_release_i,
  input wire logic        release_o,
  input wire logic        conv_start_o,
  input wire logic        busy_o,
  input wire logic        rd_req_i,
  input wire logic [1:0]  rd_seq_i,
  input wire logic        rd_valid_o,
  input wire logic [15:0] fifo_count_o,
  input wire logic [3:0]  overflow_o,
  input wire logic [3:0]  underflow_o,
  input wire logic [3:0]  overflow_clr_i,
  input wire logic [3:0]  underflow_clr_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Reference select follows the written value one cycle on
  a_ref_write: assert property (
    ref_wr_i |=> external_reference_sel_o == $past(ref_wr_data_i))
    else $error("reference select not written");
  a_release_out: assert property (release_o == (sw_start_i && sw_release_i))
    else $error("release pulse wrong");
  // Reads answer next cycle unless the fifo is empty
  a_rd_answer: assert property (
    rd_req_i && fifo_count_o[rd_seq_i*4+:4] != 4'h0 |=> rd_valid_o)
    else $error("read not answered");
  a_rd_empty: assert property (
    rd_req_i && fifo_count_o[rd_seq_i*4+:4] == 4'h0 && underflow_clr_i == 4'h0
    |=> !rd_valid_o && underflow_o[$past(rd_seq_i)])
    else $error("empty read not flagged");
  // Flags only drop where a clear was given
  a_ovf_sticky: assert property (
    &(overflow_o | ~$past(overflow_o) | $past(overflow_clr_i)))
    else $error("overflow flag dropped");
  a_unf_sticky: assert property (
    &(underflow_o | ~$past(underflow_o) | $past(underflow_clr_i)))
    else $error("underflow flag dropped");
  a_cap_depth: assert property (
    fifo_count_o[3:0] <= 4'h8 && fifo_count_o[7:4] <= 4'h4
    && fifo_count_o[11:8] <= 4'h4 && fifo_count_o[15:12] <= 4'h1)
    else $error("fifo count above depth");
  // Phase k gives k cycles of delay here, since a period is 16 cycles
  a_phase_zero: assert property ($rose(busy_o) && phase_sel_i == 4'h0 |=> conv_start_o)
    else $error("zero phase start late");
  // Every cycle of the fifteen-cycle wait is checked, not only its end
  a_phase_max: assert property (
    $rose(busy_o) && phase_sel_i == 4'hF && CONV_CYCLES == 16
    |=> !conv_start_o [*8] ##1 !conv_start_o [*7] ##1 conv_start_o)
    else $error("largest phase delay wrong");
endmodule : seq_ctrl_asserts
bind sample_seq_ctrl seq_ctrl_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk_sys_i, .sys_rst_i, .phase_sel_i, .ref_wr_i, .ref_wr_data_i, .external_reference_sel_o,
  .sw_start_i, .sw_release_i, .release_o, .conv_start_o, .busy_o, .rd_req_i, .rd_seq_i,
  .rd_valid_o, .fifo_count_o, .overflow_o, .underflow_o, .overflow_clr_i, .underflow_clr_i
);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys_i, sys_rst_i, ref_wr_i, ref_wr_data_i, external_reference_sel_o;
  logic        sw_start_i, sw_hold_i, sw_release_i, peer_release_i, release_o, free_run;
  logic        conv_start_o, conv_done_i, rd_req_i, rd_valid_o, busy_o;
  logic [1:0]  sw_start_seq_i, conv_seq_o, rd_seq_i;
  logic [2:0]  conv_step_o;
  logic [3:0]  seq_enable_i, phase_sel_i, overflow_o, underflow_o, overflow_clr_i;
  logic [3:0]  underflow_clr_i;
  logic [7:0]  seq_prio_i;
  logic [8:0]  src;
  logic [9:0]  conv_data_i, rd_data_o, dat;
  logic [11:0] seq_last_step_i;
  logic [15:0] seq_trig_sel_i, fifo_count_o;
  logic [4:0]  exp_cv[$];
  logic [9:0]  exp_rd[$], mdl[4][$];
  int          seed, fail_count, checked, lat, cur, runs;

  sample_seq_ctrl #(.CONV_CYCLES(16)) u_dut (
    .clk_sys_i, .sys_rst_i, .seq_enable_i, .seq_trig_sel_i, .seq_prio_i, .seq_last_step_i,
    .phase_sel_i, .ref_wr_i, .ref_wr_data_i, .external_reference_sel_o, .sw_start_i,
    .sw_start_seq_i, .sw_hold_i, .sw_release_i, .peer_release_i, .release_o,
    .analog_cmp_a_source_i(src[0]), .analog_cmp_b_source_i(src[1]),
    .analog_cmp_c_source_i(src[2]), .ext_trig_pin_i(src[3]), .timer_trig_i(src[4]),
    .pulse_gen_a_source_i(src[5]), .pulse_gen_b_source_i(src[6]),
    .pulse_gen_c_source_i(src[7]), .pulse_gen_d_source_i(src[8]), .conv_start_o,
    .conv_seq_o, .conv_step_o, .conv_done_i, .conv_data_i, .rd_req_i, .rd_seq_i, .rd_valid_o,
    .rd_data_o, .fifo_count_o, .overflow_o, .underflow_o, .overflow_clr_i, .underflow_clr_i,
    .busy_o
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic final_report;
    $display("counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick

  function automatic int dep(input int s);
    return s == 0 ? 8 : (s == 3 ? 1 : 4);
  endfunction : dep

  // Note the starts a run should make; last step is clipped to the depth
  task automatic expect_run(input int s);
    int last;
    last = seq_last_step_i[3*s+:3];
    if (last > dep(s) - 1) last = dep(s) - 1;
    for (int i = 0; i <= last; i++) exp_cv.push_back(5'(s * 8 + i));
  endtask : expect_run

  // Pin trigger is held longer to get through the synchroniser
  task automatic fire(input int code);
    src[code-1] = 1'b1;
    tick(code == 4 ? 3 : 1);
    src = 9'h0;
  endtask : fire

  task automatic sw_go(input logic [1:0] s, input logic h, input logic r);
    sw_start_i = 1'b1;
    sw_start_seq_i = s;
    sw_hold_i = h;
    sw_release_i = r;
    #1;
    cmp(16'(release_o), 16'(r), "release out");
    tick(1);
    sw_start_i = 1'b0;
  endtask : sw_go

  task automatic settle;
    int n;
    n = 0;
    tick(2);
    while ((busy_o !== 1'b0 || exp_cv.size() != 0) && n < 500) begin
      tick(1);
      n++;
    end
    cmp(16'(n < 500), 16'h1, "run finished");
    tick(4);
  endtask : settle

  // Pop everything held, plus extra reads past empty
  task automatic drain(input int s, input int extra);
    int n;
    n = mdl[s].size();
    cmp(16'(fifo_count_o[4*s+:4]), 16'(n), "fifo count");
    repeat (n + extra) begin
      rd_req_i = 1'b1;
      rd_seq_i = 2'(s);
      if (mdl[s].size() != 0) exp_rd.push_back(mdl[s].pop_front());
      tick(1);
    end
    rd_req_i = 1'b0;
    tick(2);
    cmp(16'(fifo_count_o[4*s+:4]), 16'h0, "fifo empty");
    cmp(16'(underflow_o[s]), 16'(extra != 0), "underflow");
  endtask : drain

  // Converter stand-in: random latency, keeps what the fifo can hold
  always @(negedge clk_sys_i) begin
    conv_done_i <= 1'b0;
    if (conv_start_o === 1'b1) begin
      lat = 1 + ($random(seed) & 3);
      cur = conv_seq_o;
    end else if (lat != 0) begin
      lat--;
      if (lat == 0) begin
        dat = 10'($random(seed));
        conv_done_i <= 1'b1;
        conv_data_i <= dat;
        if (mdl[cur].size() < dep(cur)) mdl[cur].push_back(dat);
      end
    end
  end

  // Scoreboard: any read, or any start outside free run, with no note pending is a fault
  always @(negedge clk_sys_i) begin
    if (conv_start_o === 1'b1) begin
      if (free_run) runs++;
      if (free_run) cmp({conv_seq_o, conv_step_o}, 16'h18, "free start");
      else if (exp_cv.size() == 0) cmp(16'h1, 16'h0, "unexpected start");
      else cmp({conv_seq_o, conv_step_o}, exp_cv.pop_front(), "start");
    end
    if (rd_valid_o === 1'b1) begin
      if (exp_rd.size() == 0) cmp(16'h1, 16'h0, "unexpected read");
      else cmp(rd_data_o, exp_rd.pop_front(), "read data");
    end
  end

  initial begin
    #1000000;
    fail_count++;
    final_report();
  end

  initial begin
    seed = 32'hBE51;
    {sys_rst_i, ref_wr_i, ref_wr_data_i, sw_start_i, sw_hold_i, sw_release_i} = 6'h20;
    {peer_release_i, rd_req_i, free_run} = 3'h0;
    {sw_start_seq_i, rd_seq_i, seq_enable_i, phase_sel_i, overflow_clr_i, underflow_clr_i} = 20'h0;
    // Converter result pins belong to the stand-in process alone
    {seq_prio_i, src, seq_last_step_i, seq_trig_sel_i} = 45'h0;
    tick(5);
    sys_rst_i = 1'b0;
    cmp({external_reference_sel_o, overflow_o, underflow_o, busy_o}, 16'h0, "reset");
    for (int v = 1; v >= 0; v--) begin
      ref_wr_i = 1'b1;
      ref_wr_data_i = v[0];
      tick(1);
      ref_wr_i = 1'b0;
      tick(1);
      cmp(16'(external_reference_sel_o), 16'(v), "reference");
    end
    $display("test reference done");
    // Each of the nine hardware sources on sequence 1; others disabled with random codes
    for (int c = 1; c <= 9; c++) begin
      seq_enable_i = 4'h0;
      seq_trig_sel_i = 16'($random(seed));
      seq_trig_sel_i[7:4] = 4'(c);
      seq_last_step_i = 12'($random(seed));
      phase_sel_i = c == 1 ? 4'h0 : (c == 2 ? 4'hF : 4'($random(seed)));
      tick(1);
      seq_enable_i = 4'h2;
      fire(c % 9 + 1);
      tick(20);
      expect_run(1);
      fire(c);
      settle();
      drain(1, 0);
    end
    $display("test trigger sources done");
    seq_enable_i = 4'h0;
    seq_trig_sel_i = 16'h0500;
    seq_prio_i = 8'h1B;
    tick(1);
    seq_enable_i = 4'hC;
    sw_go(2'h2, 1'b0, 1'b1);
    tick(20);
    expect_run(3);
    sw_go(2'h3, 1'b0, 1'b0);
    settle();
    sw_go(2'h3, 1'b1, 1'b0);
    tick(20);
    expect_run(3);
    peer_release_i = 1'b1;
    tick(1);
    peer_release_i = 1'b0;
    settle();
    cmp(16'(overflow_o), 16'h8, "overflow");
    drain(3, 1);
    overflow_clr_i = 4'hF;
    underflow_clr_i = 4'hF;
    tick(1);
    overflow_clr_i = 4'h0;
    underflow_clr_i = 4'h0;
    tick(1);
    cmp({overflow_o, underflow_o}, 16'h0, "flags cleared");
    $display("test software start done");
    // All four pending at once, priorities rotated
    for (int r = 0; r < 4; r++) begin
      seq_enable_i = 4'h0;
      seq_trig_sel_i = 16'h5555;
      seq_last_step_i = 12'($random(seed));
      for (int s = 0; s < 4; s++) seq_prio_i[2*s+:2] = 2'(s + r);
      tick(1);
      seq_enable_i = 4'hF;
      for (int p = 0; p < 4; p++) expect_run((p - r) & 3);
      fire(5);
      settle();
      for (int s = 0; s < 4; s++) drain(s, 0);
    end
    $display("test priority done");
    seq_enable_i = 4'h0;
    seq_trig_sel_i = 16'hF000;
    phase_sel_i = 4'h0;
    free_run = 1'b1;
    tick(1);
    seq_enable_i = 4'h8;
    tick(80);
    seq_enable_i = 4'h0;
    settle();
    free_run = 1'b0;
    cmp(16'(runs >= 4), 16'h1, "free run repeats");
    cmp(16'(overflow_o), 16'h8, "free run overflow");
    drain(3, 0);
    $display("test always trigger done");
    final_report();
  end
endmodule : tb
`default_nettype wire
